// file: verilog/wcrc_host.sv
// write checksum host: register slave, burst framer and pin driver
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module wcrc_host
  import wcrc_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic [WCRC_ADDR_W-1:0] i_awaddr,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  output logic      [1:0]             o_bresp,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  input  wire logic [WCRC_ADDR_W-1:0] i_araddr,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  output logic      [31:0]            o_rdata,
  output logic      [1:0]             o_rresp,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic                        o_wr_cmd,
  output logic                        o_mpr_cmd,
  output logic      [9:0]             o_col,
  output logic      [15:0]            o_dq,
  output logic      [15:0]            o_dq_oe,
  output logic      [1:0]             o_mask_lane,
  output logic      [1:0]             o_mask_lane_oe,
  input  wire logic                   i_alert_n
);

  wcrc_cfg_t               cfg;
  wcrc_cfg_t               cfg_q;
  wcrc_state_t             state_q;
  logic [31:0]             ctrl_q;
  logic [31:0]             data_q [4];
  logic [15:0]             mask_q;
  logic [7:0]              gap_min_q;
  logic [7:0]              gap_q;
  logic [7:0]              forbid_gap;
  logic                    pend_q;
  logic                    alert_err_q;
  logic                    cfg_err_q;
  logic                    mpr_ref_q;
  logic                    aw_got_q;
  logic                    w_got_q;
  logic [WCRC_ADDR_W-1:0]  awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    wr_fire;
  logic [31:0]             wr_val;
  logic [2:0]              st_clr;
  logic                    go_burst;
  logic                    go_mpr;
  logic                    conflict;
  logic                    gap_ok;
  logic                    issue;
  logic                    drop;
  logic [127:0]            data_all;
  logic [71:0]             cw_d [2];
  logic [7:0]              crc_d [2];
  logic [71:0]             cw_q [2];
  logic [7:0]              crc_q [2];
  logic [3:0]              beat_q;
  logic [32:0]             rd_aw;
  logic [32:0]             rd_ar;

  // read mux; bit 32 marks an address with no register behind it
  function automatic logic [32:0] rd_mux(input logic [WCRC_ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (a)
      WCRC_ADDR_CTRL:  r[31:0] = ctrl_q;
      WCRC_ADDR_DATA0: r[31:0] = data_q[0];
      WCRC_ADDR_DATA1: r[31:0] = data_q[1];
      WCRC_ADDR_DATA2: r[31:0] = data_q[2];
      WCRC_ADDR_DATA3: r[31:0] = data_q[3];
      WCRC_ADDR_MASK:  r[15:0] = mask_q;
      WCRC_ADDR_GO:    r[31:0] = 32'h0000_0000;
      WCRC_ADDR_STAT:  r[3:0]  = {mpr_ref_q, cfg_err_q, alert_err_q, pend_q | (state_q != ST_IDLE)};
      WCRC_ADDR_CRC:   r[15:0] = {crc_q[1], crc_q[0]};
      WCRC_ADDR_GAP:   r[7:0]  = gap_min_q;
      default:         r[32]   = 1'b1;
    endcase
    return r;
  endfunction

  // pins for one beat of the frame held in cw_q and crc_q
  function automatic wcrc_pins_t beat_pins(input logic [3:0] b);
    wcrc_pins_t p;
    p.mask_lane = 2'b11;
    p.dq        = 16'hffff;
    if (b < WCRC_DATA_BEATS) begin
      for (int k = 0; k < 2; k++) begin
        for (int n = 0; n < 8; n++) begin
          p.dq[8 * k + n] = cw_q[k][8 * n + int'(b)];
        end
        p.mask_lane[k] = cw_q[k][64 + int'(b)];
      end
    end else if (b == WCRC_CRC_BEAT0) begin
      if (cfg_q.width == WCRC_X4) begin
        p.dq[3:0] = crc_q[0][3:0];
      end else begin
        p.dq = {crc_q[1], crc_q[0]};
      end
    end else if (cfg_q.width == WCRC_X4) begin
      p.dq[3:0] = crc_q[0][7:4];
    end
    return p;
  endfunction

  // live configuration and the frame that would be sent now
  assign cfg      = wcrc_cfg_t'(ctrl_q[WCRC_CFG_W-1:0]);
  assign data_all = {data_q[3], data_q[2], data_q[1], data_q[0]};
  assign conflict = cfg.mask_en && cfg.dbi_en;

  for (genvar k = 0; k < 2; k++) begin : g_tree
    assign cw_d[k] = wcrc_build_cw(data_all, mask_q, cfg, 1'(k));
    wcrc_tree u_tree (
      .i_cw  (cw_d[k]),
      .o_crc (crc_d[k])
    );
  end

  // write decode; byte strobes merge into the old word
  assign rd_aw    = rd_mux(awaddr_q); // a call result cannot be selected directly
  assign rd_ar    = rd_mux(i_araddr);
  assign wr_fire  = aw_got_q && w_got_q && !o_bvalid;
  assign wr_val   = (rd_aw[31:0] & ~{{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}) | (wdata_q & {{8{wstrb_q[3]}},
                     {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
  assign go_burst = wr_fire && awaddr_q == WCRC_ADDR_GO && wstrb_q[0] && wdata_q[WCRC_GO_BURST];
  assign go_mpr   = wr_fire && awaddr_q == WCRC_ADDR_GO && wstrb_q[0] && wdata_q[WCRC_GO_MPR];
  assign st_clr   = (wr_fire && awaddr_q == WCRC_ADDR_STAT && wstrb_q[0]) ? wdata_q[3:1] : 3'h0;

  // spacing guard: with the checksum on, a write never leaves at the forbidden gap
  assign forbid_gap = cfg.pre2 ? WCRC_FORBID_PRE2 : WCRC_FORBID_PRE1;
  assign gap_ok     = gap_q >= gap_min_q && !(cfg.crc_en && gap_q == forbid_gap);
  assign issue      = state_q == ST_WAIT && gap_ok && !conflict;
  assign drop       = state_q == ST_WAIT && conflict;

  // address and data channels are taken independently, in either order
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_q  <= 1'b1;
        awaddr_q  <= i_awaddr;
        o_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_got_q  <= 1'b0;
      end else begin
        o_awready <= !aw_got_q && !o_bvalid;
      end
      if (i_wvalid && o_wready) begin
        w_got_q  <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
        o_wready <= 1'b0;
      end else if (wr_fire) begin
        w_got_q  <= 1'b0;
      end else begin
        o_wready <= !w_got_q && !o_bvalid;
      end
    end
  end

  // write response
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= WCRC_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= rd_aw[32] ? WCRC_RESP_SLVERR : WCRC_RESP_OKAY;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // read channel: one read at a time, answered on the edge that accepts the address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= WCRC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_ar[31:0];
      o_rresp   <= rd_ar[32] ? WCRC_RESP_SLVERR : WCRC_RESP_OKAY;
    end else if (o_rvalid) begin
      o_rvalid  <= !i_rready;
    end else begin
      o_arready <= 1'b1;
    end
  end

  // software registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q    <= WCRC_CTRL_RST;
      mask_q    <= WCRC_MASK_RST;
      gap_min_q <= WCRC_GAP_MIN_RST;
      for (int i = 0; i < 4; i++) begin
        data_q[i] <= 32'h0000_0000;
      end
    end else if (wr_fire) begin
      case (awaddr_q)
        WCRC_ADDR_CTRL:  ctrl_q    <= {14'h0000, wr_val[WCRC_CFG_W-1:0]};
        WCRC_ADDR_DATA0: data_q[0] <= wr_val;
        WCRC_ADDR_DATA1: data_q[1] <= wr_val;
        WCRC_ADDR_DATA2: data_q[2] <= wr_val;
        WCRC_ADDR_DATA3: data_q[3] <= wr_val;
        WCRC_ADDR_MASK:  mask_q    <= wr_val[15:0];
        WCRC_ADDR_GAP:   gap_min_q <= wr_val[7:0];
        default: ;
      endcase
    end
  end

  // sticky status; a new event in the clearing cycle wins over the clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alert_err_q <= 1'b0;
      cfg_err_q   <= 1'b0;
      mpr_ref_q   <= 1'b0;
      o_mpr_cmd   <= 1'b0;
    end else begin
      alert_err_q <= (!i_alert_n && cfg.crc_en) || (alert_err_q && !st_clr[0]);
      cfg_err_q   <= (go_burst && conflict) || drop || (cfg_err_q && !st_clr[1]);
      mpr_ref_q   <= (go_mpr && cfg.crc_en) || (mpr_ref_q && !st_clr[2]);
      o_mpr_cmd   <= go_mpr && !cfg.crc_en;
    end
  end

  // pending request; a go while one waits merges with it, a go in its issue cycle stays pending
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else if (go_burst && !conflict) begin
      pend_q <= 1'b1;
    end else if (issue || drop) begin
      pend_q <= 1'b0;
    end
  end

  // clocks since the last column command, saturating
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_q <= WCRC_GAP_RST;
    end else if (issue) begin
      gap_q <= 8'h01;
    end else if (gap_q != WCRC_GAP_MAX) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // burst sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (pend_q) state_q <= ST_WAIT;
        ST_WAIT: if (issue || drop) state_q <= issue ? ST_BEAT : ST_IDLE;
        ST_BEAT: if (beat_q == WCRC_LAST_BEAT) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // frame capture at the command; the frame is frozen for its ten beats
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_cmd <= 1'b0;
      o_col    <= 10'h000;
      cfg_q    <= wcrc_cfg_t'(WCRC_CTRL_RST[WCRC_CFG_W-1:0]);
      beat_q   <= 4'h0;
      for (int k = 0; k < 2; k++) begin
        cw_q[k]  <= '1;
        crc_q[k] <= 8'h00;
      end
    end else begin
      o_wr_cmd <= issue;
      if (issue) begin
        cfg_q  <= cfg;
        beat_q <= 4'h0;
        o_col  <= {cfg.col[9:3], cfg.bc4 & cfg.a2, 2'b00};
        for (int k = 0; k < 2; k++) begin
          cw_q[k]  <= cw_d[k];
          crc_q[k] <= crc_d[k];
        end
      end else if (state_q == ST_BEAT) begin
        beat_q <= beat_q + 4'h1;
      end
    end
  end

  // pin drivers; idle lanes rest at ones with enables low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {o_mask_lane, o_dq} <= 18'h3ffff;
      o_dq_oe             <= 16'h0000;
      o_mask_lane_oe      <= 2'b00;
    end else if (state_q == ST_BEAT) begin
      {o_mask_lane, o_dq} <= beat_pins(beat_q);
      o_dq_oe        <= cfg_q.width == WCRC_X4 ? WCRC_DQ_OE_X4 :
                        cfg_q.width == WCRC_X8 ? WCRC_DQ_OE_X8 : WCRC_DQ_OE_X16;
      o_mask_lane_oe <= cfg_q.width == WCRC_X4 ? 2'b00 :
                        cfg_q.width == WCRC_X8 ? 2'b01 : 2'b11;
    end else begin
      {o_mask_lane, o_dq} <= 18'h3ffff;
      o_dq_oe             <= 16'h0000;
      o_mask_lane_oe      <= 2'b00;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_data_beats;
    o_dq_oe[0] [*8];
  endsequence

  sequence s_crc_beats;
    (o_dq_oe[0] && o_mask_lane == 2'b11) [*2];
  endsequence

  a_burst_shape: assert property (
    o_wr_cmd |-> ##1 s_data_beats ##1 s_crc_beats ##1 !o_dq_oe[0])
    else $error("burst does not span eight data and two checksum beats");

  a_no_mask_dbi: assert property (
    o_wr_cmd |-> !(cfg_q.mask_en && cfg_q.dbi_en))
    else $error("write issued with masking and inversion both on");

  a_gap_forbid: assert property (
    o_wr_cmd && cfg_q.crc_en |-> $past(gap_q) != (cfg_q.pre2 ? WCRC_FORBID_PRE2 : WCRC_FORBID_PRE1))
    else $error("column command at forbidden spacing");

  a_mpr_block: assert property (
    o_mpr_cmd |-> !$past(cfg.crc_en))
    else $error("register write issued with checksum on");

  a_col_fixed: assert property (
    o_wr_cmd && !cfg_q.bc4 |-> o_col[2:0] == 3'b000)
    else $error("full burst column low bits not zero");

  a_critical_half: assert property (
    o_wr_cmd && cfg_q.bc4 |-> o_col[2] == cfg_q.a2 && o_col[1:0] == 2'b00)
    else $error("chopped burst column bit 2 wrong");

  a_crc_beat8: assert property (
    o_wr_cmd && cfg_q.width == WCRC_X16 |-> ##9 o_dq == {crc_q[1], crc_q[0]})
    else $error("checksum not on beat eight");

  a_x4_lanes: assert property (
    o_wr_cmd && cfg_q.width == WCRC_X4 |-> ##9 o_dq[3:0] == crc_q[0][3:0]
                                          ##1 o_dq[3:0] == crc_q[0][7:4])
    else $error("x4 checksum beats mapped wrong");

  a_beat9_ones: assert property (
    o_wr_cmd && cfg_q.width != WCRC_X4 |-> ##10 o_dq == 16'hffff)
    else $error("beat nine not all ones");

  a_idle_ones: assert property (
    !o_dq_oe[0] || (!cfg_q.mask_en && !cfg_q.dbi_en && o_dq_oe[0] && o_mask_lane_oe == 2'b00)
    |-> o_mask_lane == 2'b11)
    else $error("unused mask lane not at ones");

  a_alert_sticky: assert property (
    !i_alert_n && cfg.crc_en |=> alert_err_q [*2])
    else $error("alert not held in status");

endmodule // wcrc_host

`default_nettype wire

// file: verilog/wcrc_pkg.sv
// package: register map, field types and checksum helpers of the write checksum host
package wcrc_pkg;

  localparam int unsigned WCRC_ADDR_W = 8;

  // register byte offsets, one aligned word each
  localparam logic [7:0] WCRC_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] WCRC_ADDR_DATA0 = 8'h04;
  localparam logic [7:0] WCRC_ADDR_DATA1 = 8'h08;
  localparam logic [7:0] WCRC_ADDR_DATA2 = 8'h0c;
  localparam logic [7:0] WCRC_ADDR_DATA3 = 8'h10;
  localparam logic [7:0] WCRC_ADDR_MASK  = 8'h14;
  localparam logic [7:0] WCRC_ADDR_GO    = 8'h18;
  localparam logic [7:0] WCRC_ADDR_STAT  = 8'h1c;
  localparam logic [7:0] WCRC_ADDR_CRC   = 8'h20;
  localparam logic [7:0] WCRC_ADDR_GAP   = 8'h24;

  // values after reset, and the ceiling of the gap counter
  localparam logic [31:0] WCRC_CTRL_RST    = 32'h0000_0000;
  localparam logic [15:0] WCRC_MASK_RST    = 16'hffff;
  localparam logic [7:0]  WCRC_GAP_MIN_RST = 8'h01;
  localparam logic [7:0]  WCRC_GAP_RST     = 8'hff;
  localparam logic [7:0]  WCRC_GAP_MAX     = 8'hff;

  // bit positions in the go word, and the control word width
  localparam int WCRC_GO_BURST = 0;
  localparam int WCRC_GO_MPR   = 1;
  localparam int WCRC_CFG_W    = 18;

  // burst shape, spacing and checksum polynomial
  localparam logic [3:0] WCRC_DATA_BEATS  = 4'h8;
  localparam logic [3:0] WCRC_CRC_BEAT0   = 4'h8;
  localparam logic [3:0] WCRC_LAST_BEAT   = 4'h9;
  localparam logic [7:0] WCRC_FORBID_PRE1 = 8'h04;
  localparam logic [7:0] WCRC_FORBID_PRE2 = 8'h06;
  localparam logic [7:0] WCRC_POLY        = 8'h07;

  // lanes driven per part width
  localparam logic [15:0] WCRC_DQ_OE_X4   = 16'h000f;
  localparam logic [15:0] WCRC_DQ_OE_X8   = 16'h00ff;
  localparam logic [15:0] WCRC_DQ_OE_X16  = 16'hffff;

  localparam logic [1:0] WCRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WCRC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WCRC_X4  = 2'b00,
    WCRC_X8  = 2'b01,
    WCRC_X16 = 2'b10
  } wcrc_width_t;

  // control word layout, bit 0 is crc_en
  typedef struct packed {
    logic [9:0]  col;
    logic        a2;
    logic        bc4;
    logic        pre2;
    wcrc_width_t width;
    logic        dbi_en;
    logic        mask_en;
    logic        crc_en;
  } wcrc_cfg_t;

  // one beat on the pins
  typedef struct packed {
    logic [1:0]  mask_lane;
    logic [15:0] dq;
  } wcrc_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BEAT = 2'b10
  } wcrc_state_t;

  // serial form of x^8+x^2+x+1, bit 71 first, zero start
  function automatic logic [7:0] wcrc_crc8(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? WCRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // code word of byte k exactly as it goes on the wire
  function automatic logic [71:0] wcrc_build_cw(input logic [127:0] data,
                                                input logic [15:0]  mask,
                                                input wcrc_cfg_t    cfg,
                                                input logic         k);
    logic [71:0] cw;
    logic [7:0]  bv;
    logic        lane;
    logic        used;
    int          sb;
    int          kk;
    cw = '1;
    kk = int'(k);
    for (int b = 0; b < 8; b++) begin
      // chopped burst: low column bit 2 picks the half that is sent, in beats 0 to 3
      sb = b + (((cfg.bc4 && cfg.a2) && b < 4) ? 4 : 0);
      used = !(cfg.bc4 && b >= 4) && !(k && cfg.width != WCRC_X16);
      for (int n = 0; n < 8; n++) begin
        bv[n] = data[64 * kk + 8 * n + sb];
      end
      lane = 1'b1;
      if (used) begin
        if (cfg.width == WCRC_X4) begin
          bv[7:4] = 4'hf;
        end else if (cfg.mask_en) begin
          lane = mask[8 * kk + sb];
        end else if (cfg.dbi_en && $countones(~bv) > 4) begin
          bv   = ~bv;
          lane = 1'b0;
        end
        for (int n = 0; n < 8; n++) begin
          cw[8 * n + b] = bv[n];
        end
        cw[64 + b] = lane;
      end
    end
    return cw;
  endfunction

endpackage

// file: verilog/wcrc_tree.sv
// combinational 8-bit checksum over one 72-bit code word
`timescale 1ns/1ps
`default_nettype none

module wcrc_tree
  import wcrc_pkg::*;
(
  input  wire logic [71:0] i_cw,
  output logic      [7:0]  o_crc
);

  // unrolled by synthesis into one xor tree per bit, all eight bits
  // follow from the polynomial, so no hand-written equation can drift
  assign o_crc = wcrc_crc8(i_cw);

endmodule // wcrc_tree

`default_nettype wire

// file: test/wcrc_dev_model.sv
// device model: takes write bursts, checks their checksum, pulls alert
`timescale 1ns/1ps
`default_nettype none
module wcrc_dev_model
  import wcrc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_cmd,
  input  wire logic        i_mpr_cmd,
  input  wire logic [15:0] i_dq,
  input  wire logic [1:0]  i_ml,
  input  wire wcrc_width_t i_width,
  input  wire logic [3:0]  i_en,
  input  wire logic        i_flip,
  output logic             o_alert_n,
  output logic [7:0]       o_bursts,
  output logic [7:0]       o_errs,
  output logic [7:0]       o_mprs,
  output logic [63:0]      o_store
);
  logic [15:0] dq_b [10];
  logic [1:0]  ml_b [10];
  int          beat;
  int          gap;

  // serial form, bit 71 first; the loop unrolls to one xor tree per bit
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // i_en is {pre2, dbi, mask, crc}; alert is low for one clock per bad burst
  always @(posedge i_clk or posedge i_rst) begin
    logic [71:0] cw;
    logic [63:0] st;
    logic [7:0]  rx;
    logic        bad;
    if (i_rst) begin
      beat = -1;
      gap = 0;
      o_alert_n <= 1'b1;
      o_bursts <= 8'h00;
      o_errs <= 8'h00;
      o_mprs <= 8'h00;
      o_store <= '1;
    end else begin
      o_alert_n <= 1'b1;
      if (i_mpr_cmd) o_mprs <= o_mprs + 8'h01;
      if (i_wr_cmd && i_en[0] && gap == (i_en[3] ? 6 : 4)) o_errs <= o_errs + 8'h01;
      gap = i_wr_cmd ? 1 : gap + 1;
      if (beat >= 0) begin
        dq_b[beat] = i_dq;
        ml_b[beat] = i_ml;
      end
      // judge only once both checksum beats are in
      if (beat == 9) begin
        bad = 1'b0;
        st = o_store;
        for (int k = 0; k < 2; k++) begin
          if (k == 0 || i_width == WCRC_X16) begin
            cw = '1;
            for (int b = 0; b < 8; b++) begin
              for (int n = 0; n < 8; n++) begin
                if (i_width != WCRC_X4 || n < 4) cw[8*n+b] = dq_b[b][8*k+n];
                if (k == 0) st[8*n+b] = cw[8*n+b] ^ (i_en[2] & ~ml_b[b][0]);
              end
              if (i_width != WCRC_X4) cw[64+b] = ml_b[b][k];
            end
            cw[0] = cw[0] ^ i_flip;
            rx = (i_width == WCRC_X4) ? {dq_b[9][3:0], dq_b[8][3:0]} : dq_b[8][8*k+:8];
            bad = bad | (crc8(cw) != rx);
          end
        end
        o_bursts <= o_bursts + 8'h01;
        if (bad && i_en[0]) begin
          o_alert_n <= 1'b0;
          o_errs <= o_errs + 8'h01;
        end
        if (!(bad && i_en[1])) o_store <= st;
      end
      if (beat >= 0) beat = (beat == 9) ? -1 : beat + 1;
      if (i_wr_cmd) beat = 0;
    end
  end
endmodule // wcrc_dev_model
`default_nettype wire

// file: test/tb_write_crc_checker.sv
// self-checking bench: host under test against the device model
`timescale 1ns/1ps
`default_nettype none
module tb_write_crc_checker;
  import wcrc_pkg::*;
  localparam logic [1:0] OK = WCRC_RESP_OKAY;
  localparam logic [1:0] ER = WCRC_RESP_SLVERR;
  localparam logic [127:0] DAT = 128'h0123456789abcdef_fedcba9876543210;
  logic        i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_alert_n;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wr_cmd, o_mpr_cmd, flip;
  logic [7:0]  i_awaddr, i_araddr, bursts, errs, mprs, nb;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb, en;
  logic [1:0]  o_bresp, o_rresp, o_mask_lane, o_mask_lane_oe;
  logic [9:0]  o_col;
  logic [15:0] o_dq, o_dq_oe;
  logic [63:0] store;
  wcrc_width_t wid;
  int          error_cnt, compares;

  wcrc_host uut (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_wr_cmd, .o_mpr_cmd, .o_col, .o_dq, .o_dq_oe,
    .o_mask_lane, .o_mask_lane_oe, .i_alert_n);
  wcrc_dev_model dev (.i_clk, .i_rst, .i_wr_cmd(o_wr_cmd), .i_mpr_cmd(o_mpr_cmd), .i_dq(o_dq),
    .i_ml(o_mask_lane), .i_width(wid), .i_en(en), .i_flip(flip), .o_alert_n(i_alert_n),
    .o_bursts(bursts), .o_errs(errs), .o_mprs(mprs), .o_store(store));

  always #50 i_clk = ~i_clk;

  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a wait that ran out ends the run
  task automatic tmo(input int t);
    if (t >= 60) begin
      error_cnt++;
      $display("wait limit reached at %0t", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hf;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      t++;
    end while (o_bvalid !== 1'b1 && t < 60);
    i_bready <= 1'b0;
    tmo(t);
    chk(o_bresp, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int t;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      t++;
    end while (o_rvalid !== 1'b1 && t < 60);
    i_rready <= 1'b0;
    tmo(t);
    chk(o_rdata, e);
    chk(o_rresp, r);
  endtask

  // waits until the model has seen nb bursts and the lanes are released
  task automatic wait_burst();
    int t;
    t = 0;
    while ((bursts !== nb || o_dq_oe !== 16'h0) && t < 60) begin
      @(posedge i_clk);
      t++;
    end
    tmo(t);
  endtask

  task automatic cfg(input logic [7:0] c);
    wr(WCRC_ADDR_CTRL, {24'h0, c}, OK);
    wid <= wcrc_width_t'(c[4:3]);
    en <= {c[5], c[2:0]};
  endtask

  function automatic logic [7:0] crc_of(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // expected code word of byte k for ctrl byte c, no masking
  function automatic logic [71:0] cw_of(input int k, input logic [7:0] c);
    logic [71:0] w;
    logic [7:0]  v;
    int          s;
    w = '1;
    for (int b = 0; b < 8; b++) begin
      s = b + ((c[6] && c[7]) ? 4 : 0);
      if (!(c[6] && b >= 4) && !(k == 1 && c[4:3] != 2'b10)) begin
        for (int n = 0; n < 8; n++) v[n] = DAT[64*k+8*n+s];
        if (c[4:3] == 2'b00) v[7:4] = 4'hf;
        w[64+b] = !(c[2] && c[4:3] != 2'b00 && $countones(v) < 4);
        if (!w[64+b]) v = ~v;
        for (int n = 0; n < 8; n++) w[8*n+b] = v[n];
      end
    end
    return w;
  endfunction

  task automatic t_reset();
    chk(o_dq, 16'hffff);
    chk(o_dq_oe, 16'h0);
    chk(o_mask_lane_oe, 2'h0);
    rd(WCRC_ADDR_MASK, 32'hffff, OK);
    rd(WCRC_ADDR_GAP, 32'h1, OK);
    rd(8'h40, 32'h0, ER);
    wr(8'h40, 32'h1, ER);
    for (int i = 0; i < 4; i++) wr(WCRC_ADDR_DATA0 + 8'(4 * i), DAT[32*i+:32], OK);
    rd(WCRC_ADDR_DATA3, DAT[127:96], OK);
    $display("reset test done");
  endtask

  // every width, chop with both halves, inversion and the long preamble, two bursts each
  task automatic t_bursts();
    logic [7:0] tb [7] = '{8'h01, 8'h11, 8'hc9, 8'h51, 8'h0d, 8'h15, 8'h29};
    for (int i = 0; i < 7; i++) begin
      cfg(tb[i]);
      wr(WCRC_ADDR_GO, 32'h1, OK);
      wr(WCRC_ADDR_GO, 32'h1, OK);
      nb = nb + 8'h02;
      wait_burst();
      chk(o_col[2:0], {tb[i][6] & tb[i][7], 2'b00});
      rd(WCRC_ADDR_CRC, {16'h0, crc_of(cw_of(1, tb[i])), crc_of(cw_of(0, tb[i]))}, OK);
      chk(errs, 8'h00);
      if (!tb[i][6]) chk(store[31:0], DAT[31:0]);
    end
    $display("burst test done");
  endtask

  task automatic t_alert();
    cfg(8'h0b);
    wr(WCRC_ADDR_DATA0, 32'h0, OK);
    flip <= 1'b1;
    wr(WCRC_ADDR_GO, 32'h1, OK);
    nb = nb + 8'h01;
    wait_burst();
    flip <= 1'b0;
    rd(WCRC_ADDR_STAT, 32'h2, OK);
    chk(store, DAT[63:0]);
    wr(WCRC_ADDR_STAT, 32'h2, OK);
    rd(WCRC_ADDR_STAT, 32'h0, OK);
    $display("alert test done");
  endtask

  task automatic t_refuse();
    cfg(8'h07);
    wr(WCRC_ADDR_GO, 32'h1, OK);
    repeat (20) @(posedge i_clk);
    chk(bursts, nb);
    rd(WCRC_ADDR_STAT, 32'h4, OK);
    wr(WCRC_ADDR_STAT, 32'h4, OK);
    cfg(8'h09);
    wr(WCRC_ADDR_GO, 32'h2, OK);
    rd(WCRC_ADDR_STAT, 32'h8, OK);
    chk(mprs, 8'h00);
    cfg(8'h08);
    wr(WCRC_ADDR_GO, 32'h2, OK);
    @(posedge i_clk);
    chk(mprs, 8'h01);
    $display("refusal test done");
  endtask

  initial begin
    {error_cnt, compares, nb, flip, en, i_clk} = '0;
    wid = WCRC_X4;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_bursts();
    t_alert();
    t_refuse();
    complete_run();
  end
endmodule // tb_write_crc_checker
`default_nettype wire
